// file: inc/core_gp_timer_pkg.sv
// Package for the core general-purpose timer: register map, fields, modes.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
`default_nettype none
package core_gp_timer_pkg;
   // Register byte offsets
   localparam logic [7:0] control_offset = 8'h00;
   localparam logic [7:0] count_offset   = 8'h04;
   localparam logic [7:0] flag_offset    = 8'h08;
   // Control field positions
   localparam int input_select_lsb = 0;
   localparam int mode_select_lsb  = 3;
   localparam int run_pos          = 6;
   localparam int direction_pos    = 7;
   localparam int ext_dir_en_pos   = 8;
   localparam int output_en_pos    = 9;
   localparam int toggle_pos       = 10;
   // Writable bits of the control register; bit 5 and 15..11 read zero
   localparam logic [15:0] control_write_mask = 16'h07df;
   localparam logic [15:0] control_reset      = 16'h0000;
   localparam logic [15:0] count_reset        = 16'h0000;
   // Prescale: base divider 16, shifted by the input selection
   localparam int prescale_base_log2 = 4;
   localparam int prescale_max_log2  = 11;

   typedef enum logic [1:0] {
      mode_timer      = 2'b00,
      mode_counter    = 2'b01,
      mode_gated_low  = 2'b10,
      mode_gated_high = 2'b11
   } mode_t;
endpackage : core_gp_timer_pkg
`default_nettype wire

// file: inc/timer_tick_if.sv
// Interface between the timer top and its prescaler.
// Assumes one clock shared by both ends.
`default_nettype none
interface timer_tick_if;
   logic [2:0] input_select;   // Prescale selection
   logic       tick;           // One-cycle prescaled count pulse
   modport top (output input_select, input tick);
   modport prescaler (input input_select, output tick);
endinterface : timer_tick_if
`default_nettype wire

// file: rtl/timer_prescaler.sv
// Free-running divider making one-cycle ticks at clk / (16 * 2^sel).
// Assumes hclk is the oscillator-derived system clock.
`default_nettype none
module timer_prescaler (
   input  wire logic hclk,         // System clock
   input  wire logic hresetn,      // Async reset, active low
   timer_tick_if.prescaler tk      // Selection in, tick out
);
   localparam int max_log2 = core_gp_timer_pkg::prescale_max_log2;

   typedef struct packed {
      logic [max_log2-1:0] div;
      logic                tick;
   } state_t;

   state_t cur;
   state_t next_cur;
   logic [3:0] sel_log2;

   always_comb begin
      next_cur = cur;
      sel_log2 = 4'(core_gp_timer_pkg::prescale_base_log2)
                 + {1'b0, tk.input_select};
      next_cur.div = cur.div + 1'b1;
      // Tick when the low sel_log2 bits all wrap to ones
      next_cur.tick = &(cur.div | ~((11'h1 << sel_log2) - 11'h1));
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign tk.tick = cur.tick;
endmodule : timer_prescaler
`default_nettype wire

// file: rtl/core_gp_timer.sv
// Core general-purpose 16-bit timer with AHB-Lite register slave.
// Assumes external pins are asynchronous and are synchronised here.
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`default_nettype none
module core_gp_timer (
   input  wire logic        hclk,              // System clock
   input  wire logic        hresetn,           // Async reset, active low
   input  wire logic        hsel,              // Slave select
   input  wire logic [31:0] haddr,             // Byte address
   input  wire logic [1:0]  htrans,            // Transfer type
   input  wire logic        hwrite,            // Write strobe
   input  wire logic [2:0]  hsize,             // Transfer size
   input  wire logic [31:0] hwdata,            // Write data
   input  wire logic        hready,            // Bus ready in
   output logic      [31:0] hrdata,            // Read data
   output logic             hreadyout,         // Always ready
   output logic             hresp,             // Always OKAY
   input  wire logic        ext_gate_count_pin, // Gate or count input
   input  wire logic        ext_direction_pin, // External direction
   output logic             toggle_output_pin, // Latch state to pin
   output logic             toggle_output_sel, // Pin owned by timer
   output logic             toggle_latch,      // Internal latch route
   output logic             overflow_event,    // Wrap pulse route
   output logic             overflow_request_flag // Wrap request
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [15:0] control;
      logic [15:0] count;
      logic        flag;
      logic [1:0]  gate_sync;
      logic [1:0]  dir_sync;
      logic        gate_prev;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] rdata;
      logic        tgl_pin;
      logic        tgl_sel;
      logic        tgl_lat;
      logic        ovf_evt;
      logic        flag_out;
   } state_t;

   state_t cur;
   state_t next_cur;

   timer_tick_if tk ();

   timer_prescaler u_prescaler (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tk      (tk)
   );

   // ==========================================================
   // Decode of control fields
   logic [2:0] input_select_field;
   logic [1:0] mode_select_field;
   logic       core_run_bit;
   logic       direction_bit;
   logic       ext_direction_enable;
   logic       toggle_output_enable;
   logic       count_down;
   logic       gate_lvl;
   logic       rise;
   logic       fall;
   logic       step;
   logic       wrap;
   logic       acc;
   logic [15:0] wval;
   logic [15:0] stepped;

   assign input_select_field   =
      cur.control[core_gp_timer_pkg::input_select_lsb +: 3];
   assign mode_select_field    =
      cur.control[core_gp_timer_pkg::mode_select_lsb +: 2];
   assign core_run_bit         = cur.control[core_gp_timer_pkg::run_pos];
   assign direction_bit        =
      cur.control[core_gp_timer_pkg::direction_pos];
   assign ext_direction_enable =
      cur.control[core_gp_timer_pkg::ext_dir_en_pos];
   assign toggle_output_enable =
      cur.control[core_gp_timer_pkg::output_en_pos];
   assign tk.input_select = input_select_field;

   always_comb begin
      gate_lvl = cur.gate_sync[1];
      rise     = gate_lvl & ~cur.gate_prev;
      fall     = ~gate_lvl & cur.gate_prev;
      // Direction is combinational, so it tracks while stopped
      if (ext_direction_enable) begin
         count_down = cur.dir_sync[1] ^ direction_bit;
      end else begin
         count_down = direction_bit;
      end
      step = 1'b0;
      unique case (core_gp_timer_pkg::mode_t'(mode_select_field))
         core_gp_timer_pkg::mode_timer: begin
            step = core_run_bit & tk.tick;
         end
         core_gp_timer_pkg::mode_counter: begin
            // Select code 0 and codes with bit 2 set are reserved: no count
            unique case (input_select_field)
               3'h1:    step = core_run_bit & rise;
               3'h2:    step = core_run_bit & fall;
               3'h3:    step = core_run_bit & (rise | fall);
               default: step = 1'b0;
            endcase
         end
         core_gp_timer_pkg::mode_gated_low: begin
            step = core_run_bit & ~gate_lvl & tk.tick;
         end
         core_gp_timer_pkg::mode_gated_high: begin
            step = core_run_bit & gate_lvl & tk.tick;
         end
      endcase
      wrap = step & (count_down ? (cur.count == 16'h0000)
                                : (cur.count == 16'hffff));
      stepped = count_down ? cur.count - 16'h0001
                           : cur.count + 16'h0001;
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_cur = cur;
      acc  = hsel & htrans[1] & hready;
      wval = hwdata[15:0];

      next_cur.gate_sync = {cur.gate_sync[0], ext_gate_count_pin};
      next_cur.dir_sync  = {cur.dir_sync[0], ext_direction_pin};
      next_cur.gate_prev = cur.gate_sync[1];

      // Counting; gate edges only matter through step, never the flag
      if (step) begin
         next_cur.count = stepped;
      end
      if (wrap) begin
         next_cur.control[core_gp_timer_pkg::toggle_pos] =
            ~cur.control[core_gp_timer_pkg::toggle_pos];
      end

      // Data phase of a registered write
      if (cur.wr_pend) begin
         unique case (cur.wr_addr)
            core_gp_timer_pkg::control_offset: begin
               // Software write to the latch overrides a same-cycle wrap
               next_cur.control = wval &
                  core_gp_timer_pkg::control_write_mask;
            end
            core_gp_timer_pkg::count_offset: begin
               next_cur.count = wval;
            end
            default: begin
            end
         endcase
      end

      // Flag: write one clears, but a wrap in the same cycle wins
      if (cur.wr_pend && cur.wr_addr == core_gp_timer_pkg::flag_offset
          && wval[0]) begin
         next_cur.flag = 1'b0;
      end
      if (wrap) begin
         next_cur.flag = 1'b1;
      end

      // Address phase
      next_cur.wr_pend = acc & hwrite;
      next_cur.wr_addr = haddr[7:0];
      if (acc && !hwrite) begin
         unique case (haddr[7:0])
            core_gp_timer_pkg::control_offset:
               next_cur.rdata = {16'h0000, cur.control};
            core_gp_timer_pkg::count_offset:
               next_cur.rdata = {16'h0000, cur.count};
            core_gp_timer_pkg::flag_offset:
               next_cur.rdata = {31'h0, cur.flag};
            default:
               next_cur.rdata = 32'h0000_0000;
         endcase
      end

      // Registered outputs, one cycle behind the state, except flag_out, which tracks the flag
      next_cur.tgl_pin  = toggle_output_enable &
         cur.control[core_gp_timer_pkg::toggle_pos];
      next_cur.tgl_sel  = toggle_output_enable;
      next_cur.tgl_lat  =
         cur.control[core_gp_timer_pkg::toggle_pos];
      next_cur.ovf_evt  = wrap;
      next_cur.flag_out = next_cur.flag;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // ==========================================================
   // Outputs
   always_comb begin
      hrdata                = cur.rdata;
      hreadyout             = 1'b1;
      hresp                 = 1'b0;
      toggle_output_pin     = cur.tgl_pin;
      toggle_output_sel     = cur.tgl_sel;
      toggle_latch          = cur.tgl_lat;
      overflow_event        = cur.ovf_evt;
      overflow_request_flag = cur.flag_out;
   end
endmodule : core_gp_timer
`default_nettype wire

// file: verification/core_gp_timer_monitor.sv
// Checker of the core timer top ports.
// Assumes one clock domain; attached by bind from the bench.
`default_nettype none
module core_gp_timer_monitor (
   input wire logic        hclk,                 // Clock
   input wire logic        hresetn,              // Reset, active low
   input wire logic        hsel,                 // Slave select
   input wire logic [31:0] hrdata,               // Read data
   input wire logic        hreadyout,            // Ready out
   input wire logic        hresp,                // Response
   input wire logic        toggle_output_pin,    // Latch on pin
   input wire logic        toggle_output_sel,    // Pin owned
   input wire logic        toggle_latch,         // Latch route
   input wire logic        overflow_event,       // Wrap pulse
   input wire logic        overflow_request_flag // Wrap request
);
   // ==========================================================
   // Properties
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence wrap_s;
      overflow_event;
   endsequence
   sequence quiet_s;
      overflow_request_flag && !hsel;
   endsequence
   chk_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   chk_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   chk_upper_zero: assert property (hrdata[31:16] == 16'h0)
      else $error("upper read data not zero");
   chk_pin_follows: assert property (
      toggle_output_pin == (toggle_latch && toggle_output_sel))
      else $error("pin differs from latch and enable");
   chk_event_pulse: assert property (wrap_s |=> !overflow_event)
      else $error("wrap pulse too long");
   chk_event_flag: assert property (
      wrap_s |-> ##[0:1] overflow_request_flag)
      else $error("wrap without request");
   chk_flag_cause: assert property ($rose(overflow_request_flag) |->
      overflow_event || $past(overflow_event))
      else $error("request without wrap");
   chk_flag_sticky: assert property (
      quiet_s [*3] |=> overflow_request_flag)
      else $error("request dropped without write");
   chk_reset_clear: assert property ($rose(hresetn) |->
      !overflow_request_flag && !toggle_latch)
      else $error("outputs not clear after reset");
endmodule : core_gp_timer_monitor
`default_nettype wire

// file: verification/pin_partner.sv
// Model of the external gate, count and direction pins.
// Assumes the bench calls its tasks; levels change after hclk.
`default_nettype none
module pin_partner (
   input  wire logic hclk,     // Clock
   output logic      gate_pin, // Gate or count level
   output logic      dir_pin   // Direction level
);
   // ==========================================================
   // Drivers; the pins are only read by the timer
   initial begin
      gate_pin = 1'b0;
      dir_pin = 1'b0;
   end
   task automatic set_pins(logic g, logic d);
      @(posedge hclk);
      gate_pin <= g;
      dir_pin <= d;
   endtask : set_pins
   // Four cycles a level, above the synchroniser's two
   task automatic pulse(int n);
      for (int k = 0; k < 2 * n; k++) begin
         @(posedge hclk);
         gate_pin <= ~gate_pin;
         repeat (3) @(posedge hclk);
      end
   endtask : pulse
endmodule : pin_partner
`default_nettype wire

// file: verification/core_gp_timer_tb.sv
// Self-checking bench of the core timer over AHB-Lite.
// Assumes the monitor and pin model compiled before it.
`default_nettype none
module core_gp_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ctl_a = core_gp_timer_pkg::control_offset;
   localparam logic [7:0] cnt_a = core_gp_timer_pkg::count_offset;
   localparam logic [7:0] flg_a = core_gp_timer_pkg::flag_offset;
   localparam int         span  = 4096;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, seed, rd;
   logic [1:0]  htrans;
   logic        gate_pin, dir_pin, toggle_output_pin, toggle_output_sel;
   logic        toggle_latch, overflow_event, overflow_request_flag;
   int          num_errors, checks_done;
   core_gp_timer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .ext_gate_count_pin(gate_pin), .ext_direction_pin(dir_pin),
      .toggle_output_pin, .toggle_output_sel, .toggle_latch,
      .overflow_event, .overflow_request_flag);
   pin_partner partner (.hclk, .gate_pin, .dir_pin);
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic int edges(int s, int n);
      return (s == 3) ? 2 * n : (s == 1 || s == 2) ? n : 0;
   endfunction : edges
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("Checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
   endtask : wait_ready
   // The idle cycle up front keeps read-after-write safe
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
   endtask : xfer
   // ==========================================================
   // Scenarios
   initial begin
      logic [31:0] r;
      logic [15:0] d;
      logic [2:0]  sel;
      logic [1:0]  m;
      logic        run, dn;
      int          e, n;
      seed = 32'h3f;
      num_errors = 0;
      checks_done = 0;
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(0, ctl_a, 0);
      check("control", rd, 32'h0);
      xfer(0, 8'h40, 0);
      check("unmapped", rd, 32'h0);
      xfer(1, ctl_a, 32'hffff);
      xfer(0, ctl_a, 0);
      check("control", rd, 32'h7df);
      check("pin_on", 32'(toggle_output_pin), 1);
      check("pin_sel", 32'(toggle_output_sel), 1);
      for (int w = 0; w < 2; w++) begin
         xfer(1, ctl_a, 0);
         xfer(1, cnt_a, w ? 32'h0 : 32'hffff);
         xfer(1, flg_a, 1);
         xfer(1, ctl_a, 32'h40 | (32'(w) << 7));
         for (n = 0; n < 100 && overflow_event !== 1'b1; n++)
            @(posedge hclk);
         check("wrap_seen", 32'(n < 100), 1);
         @(posedge hclk);
         check("latch", 32'(toggle_latch), 1);
         check("pin_off", 32'(toggle_output_pin), 0);
         xfer(1, ctl_a, 32'h400);
         xfer(0, cnt_a, 0);
         check("wrap", rd, w ? 32'hffff : 32'h0);
         xfer(0, flg_a, 0);
         check("flag", rd & 32'h1, 1);
      end
      // Clear the request left by the wrap scenarios
      xfer(1, flg_a, 1);
      for (int i = 0; i < 12; i++) begin
         r = xs();
         sel = (i < 8) ? 3'(i) : 3'h0;
         m = (i < 8) ? 2'b00 : {1'b1, i[1]};
         run = (i != 3);
         partner.set_pins(i[0], r[1]);
         xfer(1, cnt_a, 32'h8000);
         xfer(1, ctl_a, {23'h0, r[3], r[2], run, 1'b0, m, sel});
         repeat (span) @(posedge hclk);
         xfer(1, ctl_a, 0);
         xfer(0, cnt_a, 0);
         e = !run ? 0 : (i < 8) ? span >> (4 + i) :
             (i[0] == i[1]) ? span >> 4 : 0;
         dn = r[3] ? r[2] ^ r[1] : r[2];
         d = dn ? 16'h8000 - rd[15:0] : rd[15:0] - 16'h8000;
         check("steps", 32'(d == e || (e > 0 && d == e + 1)), 1);
         xfer(0, flg_a, 0);
         check("no_request", rd, 32'h0);
      end
      partner.set_pins(1'b0, 1'b0);
      for (int s = 0; s < 5; s++) begin
         r = xs();
         n = int'(r[1:0]) + 1;
         xfer(1, cnt_a, 32'h8000);
         xfer(1, ctl_a, 32'h48 | 32'(s));
         partner.pulse(n);
         repeat (8) @(posedge hclk);
         xfer(0, cnt_a, 0);
         check("events", rd, 32'h8000 + 32'(edges(s, n)));
      end
      tally_and_finish();
   end
endmodule : core_gp_timer_tb
bind core_gp_timer core_gp_timer_monitor mon (.hclk, .hresetn, .hsel,
   .hrdata, .hreadyout, .hresp, .toggle_output_pin, .toggle_output_sel,
   .toggle_latch, .overflow_event, .overflow_request_flag);
`default_nettype wire
